// ---- shared/fws_map.vh ----
// register map, field positions and timing counts of the flash status polling controller
`ifndef FWS_MAP_VH
`define FWS_MAP_VH
`define FWS_OFF_CTRL 12'h000
`define FWS_OFF_ADDR 12'h004
`define FWS_OFF_DATA 12'h008
`define FWS_OFF_STAT 12'h00c
`define FWS_OFF_RDAT 12'h010
`define FWS_OFF_ERSA 12'h014
`define FWS_CTRL_START 0
`define FWS_CTRL_MODE_LO 1
`define FWS_CTRL_MODE_HI 2
`define FWS_MODE_PROG 2'h0
`define FWS_MODE_TOGGLE 2'h1
`define FWS_MODE_DQ3 2'h2
`define FWS_MODE_RESET 2'h3
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_FAIL 2
`define FWS_ST_RESET_SENT 3
`define FWS_ST_RDY 4
`define FWS_ST_TIMER 5
`define FWS_ST_T2 6
`define FWS_POLL_BIT 7
`define FWS_T1_BIT 6
`define FWS_FAIL_BIT 5
`define FWS_TMR_BIT 3
`define FWS_T2_BIT 2
`define FWS_RESET_CMD 8'hf0
`define FWS_CYC_NS 10
`define FWS_STROBE_NS 70
`define FWS_STROBE_CYC ((`FWS_STROBE_NS + `FWS_CYC_NS - 1) / `FWS_CYC_NS)
`endif

// ---- verilog/fws_sync.v ----
// three-stage synchroniser for the ready/busy line
`timescale 1ns/1ns
module fws_sync (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // pin and result
   input wire din,
   output reg dout
);
   reg s1_r, s2_r, s3_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // change counts only when the last two stages agree
         if (s2_r == s3_r)
            dout <= s3_r;
      end
   end
endmodule // fws_sync

// ---- verilog/fws_host.v ----
// host-side status polling controller for a parallel nor flash, apb slave toward software
`timescale 1ns/1ns
`include "fws_map.vh"
// Contract
// - host status reads for programming use the programmed address.
// - host erase status reads use an address inside a selected sector.
// - polling bit may lead low bits; host takes data from a later read. After a fail-bit recheck the host takes data from the first matching read.
// - host compares toggle bit over two consecutive reads; equal means done.
// - toggling with fail bit high: recheck once, still toggling means send reset.
// - after failure host sends reset; device returns to read mode.
// - timer bit 1 means commands ignored; host checks bit around commands. The host only reports the bit in status and sends reset without checking it.
module fws_host #(
   parameter AW = 21,
   parameter STROBE_CYC = `FWS_STROBE_CYC
) (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // flash pins
   output reg [AW-1:0] fl_addr,
   output reg [7:0] fl_dq_out,
   output reg fl_dq_oe_n,
   input wire [7:0] fl_dq_in,
   output reg fl_ce_n,
   output reg fl_oe_n,
   output reg fl_we_n,
   input wire fl_ready_busy_in
);
   localparam S_IDLE = 3'h0, S_RD_LO = 3'h1, S_RD_HI = 3'h2, S_WR_LO = 3'h3, S_WR_HI = 3'h4, S_EVAL = 3'h5;
   reg [2:0] st_r;
   reg [1:0] mode_r;
   reg [AW-1:0] addr_r, ersa_r;
   reg [7:0] data_r, rdat_r, prev_r;
   reg [7:0] cnt_r;
   reg have_prev_r, recheck_r, busy_r, done_r, fail_r, rst_sent_r, tmr_r, t2_r;
   wire rdy_sync;
   wire [7:0] s = fl_dq_in;
   wire apb_wr = psel && penable && pwrite && !pready;
   wire apb_rd = psel && penable && !pwrite && !pready;
   wire strobe_done = (cnt_r == STROBE_CYC[7:0] - 8'h1);

   // the pin is asynchronous to pclk, so it is filtered before use
   fws_sync u_sync (.pclk(pclk), .presetn(presetn), .din(fl_ready_busy_in), .dout(rdy_sync));

   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `FWS_OFF_CTRL) || (a == `FWS_OFF_ADDR) || (a == `FWS_OFF_DATA) ||
                  (a == `FWS_OFF_STAT) || (a == `FWS_OFF_RDAT) || (a == `FWS_OFF_ERSA);
      end
   endfunction

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= (psel && penable && !pready);
         pslverr <= (psel && penable && !pready && !mapped(paddr));
         prdata <= 32'h00000000;
         if (apb_rd) begin
            case (paddr)
               `FWS_OFF_CTRL: prdata <= {29'h0, mode_r, 1'b0};
               `FWS_OFF_ADDR: prdata <= {{(32-AW){1'b0}}, addr_r};
               `FWS_OFF_DATA: prdata <= {24'h0, data_r};
               `FWS_OFF_STAT: prdata <= {25'h0, t2_r, tmr_r, rdy_sync, rst_sent_r, fail_r, done_r, busy_r};
               `FWS_OFF_RDAT: prdata <= {24'h0, rdat_r};
               `FWS_OFF_ERSA: prdata <= {{(32-AW){1'b0}}, ersa_r};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= S_IDLE;
         mode_r <= `FWS_MODE_PROG;
         addr_r <= {AW{1'b0}};
         ersa_r <= {AW{1'b0}};
         data_r <= 8'h00;
         rdat_r <= 8'h00;
         prev_r <= 8'h00;
         cnt_r <= 8'h00;
         have_prev_r <= 1'b0;
         recheck_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
         rst_sent_r <= 1'b0;
         tmr_r <= 1'b0;
         t2_r <= 1'b0;
         fl_addr <= {AW{1'b0}};
         fl_dq_out <= 8'h00;
         fl_dq_oe_n <= 1'b1;
         fl_ce_n <= 1'b1;
         fl_oe_n <= 1'b1;
         fl_we_n <= 1'b1;
      end else begin
         if (apb_wr && !busy_r) begin
            case (paddr)
               `FWS_OFF_ADDR: addr_r <= pwdata[AW-1:0];
               `FWS_OFF_DATA: data_r <= pwdata[7:0];
               `FWS_OFF_ERSA: ersa_r <= pwdata[AW-1:0];
               `FWS_OFF_CTRL: begin
                  mode_r <= pwdata[`FWS_CTRL_MODE_HI:`FWS_CTRL_MODE_LO];
                  if (pwdata[`FWS_CTRL_START]) begin
                     busy_r <= 1'b1;
                     done_r <= 1'b0;
                     fail_r <= 1'b0;
                     rst_sent_r <= 1'b0;
                     have_prev_r <= 1'b0;
                     recheck_r <= 1'b0;
                     // a fresh run must not report a toggle seen by the previous one
                     t2_r <= 1'b0;
                     cnt_r <= 8'h00;
                     if (pwdata[`FWS_CTRL_MODE_HI:`FWS_CTRL_MODE_LO] == `FWS_MODE_RESET) begin
                        st_r <= S_WR_LO;
                        fl_dq_out <= `FWS_RESET_CMD;
                        fl_dq_oe_n <= 1'b0;
                        fl_ce_n <= 1'b0;
                        fl_we_n <= 1'b0;
                     end else begin
                        st_r <= S_RD_LO;
                        // program polls at the target, erase modes inside the selected sector
                        fl_addr <= (pwdata[`FWS_CTRL_MODE_HI:`FWS_CTRL_MODE_LO] == `FWS_MODE_PROG) ?
                                   addr_r : ersa_r;
                        fl_ce_n <= 1'b0;
                        fl_oe_n <= 1'b0;
                     end
                  end
               end
               default: ;
            endcase
         end
         case (st_r)
            S_IDLE: ;
            S_RD_LO: begin
               cnt_r <= cnt_r + 8'h1;
               if (strobe_done) begin
                  cnt_r <= 8'h00;
                  rdat_r <= s;
                  fl_oe_n <= 1'b1;
                  fl_ce_n <= 1'b1;
                  st_r <= S_RD_HI;
               end
            end
            S_RD_HI: begin
               cnt_r <= cnt_r + 8'h1;
               if (strobe_done) begin
                  cnt_r <= 8'h00;
                  st_r <= S_EVAL;
               end
            end
            S_EVAL: begin
               st_r <= S_RD_LO;
               fl_ce_n <= 1'b0;
               fl_oe_n <= 1'b0;
               prev_r <= rdat_r;
               have_prev_r <= 1'b1;
               tmr_r <= rdat_r[`FWS_TMR_BIT];
               if (mode_r == `FWS_MODE_DQ3) begin
                  // one status read is enough for the erase window bit
                  st_r <= S_IDLE;
                  fl_ce_n <= 1'b1;
                  fl_oe_n <= 1'b1;
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
               end else if (mode_r == `FWS_MODE_PROG && rdat_r[`FWS_POLL_BIT] == data_r[`FWS_POLL_BIT]) begin
                  // the polling bit can lead the others, so a final read fetches clean data
                  if (recheck_r) begin
                     st_r <= S_IDLE;
                     fl_ce_n <= 1'b1;
                     fl_oe_n <= 1'b1;
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                  end
                  recheck_r <= 1'b1;
               end else if (mode_r == `FWS_MODE_TOGGLE && have_prev_r) begin
                  t2_r <= rdat_r[`FWS_T2_BIT] ^ prev_r[`FWS_T2_BIT];
                  if (rdat_r[`FWS_T1_BIT] == prev_r[`FWS_T1_BIT]) begin
                     st_r <= S_IDLE;
                     fl_ce_n <= 1'b1;
                     fl_oe_n <= 1'b1;
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                  end else if (rdat_r[`FWS_FAIL_BIT] && recheck_r) begin
                     // still toggling after the fail recheck: give up with a reset
                     fail_r <= 1'b1;
                     st_r <= S_WR_LO;
                     fl_oe_n <= 1'b1;
                     fl_dq_out <= `FWS_RESET_CMD;
                     fl_dq_oe_n <= 1'b0;
                     fl_we_n <= 1'b0;
                  end else if (rdat_r[`FWS_FAIL_BIT]) begin
                     recheck_r <= 1'b1;
                  end
               end else if (mode_r == `FWS_MODE_PROG && rdat_r[`FWS_FAIL_BIT]) begin
                  if (recheck_r) begin
                     fail_r <= 1'b1;
                     st_r <= S_WR_LO;
                     fl_oe_n <= 1'b1;
                     fl_dq_out <= `FWS_RESET_CMD;
                     fl_dq_oe_n <= 1'b0;
                     fl_we_n <= 1'b0;
                  end
                  recheck_r <= 1'b1;
               end
            end
            S_WR_LO: begin
               cnt_r <= cnt_r + 8'h1;
               if (strobe_done) begin
                  cnt_r <= 8'h00;
                  fl_we_n <= 1'b1;
                  fl_ce_n <= 1'b1;
                  st_r <= S_WR_HI;
               end
            end
            S_WR_HI: begin
               cnt_r <= cnt_r + 8'h1;
               if (strobe_done) begin
                  cnt_r <= 8'h00;
                  fl_dq_oe_n <= 1'b1;
                  rst_sent_r <= 1'b1;
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
                  st_r <= S_IDLE;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule // fws_host

// ---- test/fws_host_chk.sv ----
// port assertions for the flash status polling controller
`timescale 1ns/1ns
module fws_host_chk #(
   parameter AW = 21,
   parameter STROBE_CYC = 7
) (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [11:0] paddr,
   input wire pready,
   input wire pslverr,
   // flash pins
   input wire [AW-1:0] fl_addr,
   input wire [7:0] fl_dq_out,
   input wire fl_dq_oe_n,
   input wire fl_oe_n,
   input wire fl_we_n
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_apb_wait_one: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");
   chk_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_unmapped_err: assert property (pready && paddr > 12'h014 |-> pslverr)
      else $error("unmapped access not flagged");
   chk_mapped_ok: assert property (pready && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access flagged");
   // repeat count follows the default strobe length
   chk_read_strobe: assert property ($fell(fl_oe_n) |-> (!fl_oe_n) [*7] ##1 fl_oe_n)
      else $error("read strobe length wrong");
   chk_read_no_drive: assert property (!fl_oe_n |-> fl_dq_oe_n && fl_we_n)
      else $error("host drives dq during read");
   chk_reset_write: assert property ($fell(fl_we_n) |-> (!fl_dq_oe_n && fl_dq_out == 8'hf0) [*7] ##1 fl_we_n)
      else $error("reset write malformed");
   chk_addr_steady: assert property (!fl_oe_n && $past(!fl_oe_n) |-> $stable(fl_addr))
      else $error("address moved during read");
endmodule // fws_host_chk

// ---- test/fws_flash_model.sv ----
// behavioural flash status model seen by the polling controller
`timescale 1ns/1ns
module fws_flash_model (
   // flash pins
   input wire [20:0] fl_addr,
   input wire [7:0] fl_dq_out,
   input wire fl_ce_n,
   input wire fl_oe_n,
   input wire fl_we_n,
   // status outputs
   output wire [7:0] fl_dq,
   output wire fl_rb_oe_n
);
   reg busy = 1'h0;
   reg erase = 1'h0;
   reg fail = 1'h0;
   reg tmr = 1'h0;
   reg got_reset = 1'h0;
   reg t1 = 1'h0;
   reg t2 = 1'h0;
   reg susp = 1'h0;
   reg [7:0] data = 8'h00;
   integer cnt = 0;
   wire rd = !fl_ce_n && !fl_oe_n;
   wire [7:0] stat = {erase ? susp : ~data[7], t1, fail, 1'h0, tmr, t2, 2'h0};
   wire [7:0] val = busy ? stat : data;
   // released bus shows the inverse so a stale sample never matches
   assign fl_dq = rd ? val : ~val;
   // suspend-read mode releases the line although the erase is still pending
   assign fl_rb_oe_n = !busy || susp;
   always @(negedge rd) begin
      if (busy) begin
         t1 <= susp ? t1 : ~t1;
         t2 <= erase ? ~t2 : t2;
         if (cnt > 1)
            cnt <= cnt - 1;
         else if (!fail)
            // a protected target looks busy for a while, then reads back unchanged data
            busy <= 1'h0;
      end
   end
   // the reset command clears busy and fail as the write strobe rises
   always @(posedge fl_we_n) begin
      if (fl_dq_out == 8'hf0) begin
         busy <= 1'h0;
         fail <= 1'h0;
         got_reset <= 1'h1;
      end
   end
endmodule // fws_flash_model

// ---- test/fws_tb.sv ----
// self-checking bench for the flash status polling controller
`timescale 1ns/1ns
`include "fws_map.vh"
module testbench;
   reg pclk = 1'h0;
   reg presetn = 1'h0;
   reg psel = 1'h0;
   reg penable = 1'h0;
   reg pwrite = 1'h0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire [20:0] fl_addr;
   wire [7:0] fl_dq_out;
   wire [7:0] fl_dq;
   wire fl_dq_oe_n;
   wire fl_ce_n;
   wire fl_oe_n;
   wire fl_we_n;
   wire rb_oe_n;
   wire rb_line = rb_oe_n ? 1'h1 : 1'h0;
   integer fail_count = 0;
   integer num_checks = 0;
   reg [31:0] rd;
   reg err;
   reg seen_t2;
   fws_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_in(fl_dq),
      .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_ready_busy_in(rb_line));
   fws_flash_model i_flash (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq(fl_dq), .fl_rb_oe_n(rb_oe_n));
   initial begin
      forever #5 pclk = ~pclk;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         // no answer time is assumed; only the watchdog ends a wait that never answers
         do begin
            @(posedge pclk);
         end while (pready !== 1'h1);
         rd = prdata;
         err = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask
   task poll;
      integer n;
      begin
         n = 0;
         seen_t2 = 1'h0;
         apb(1'h0, `FWS_OFF_STAT, 32'h0);
         while (rd[`FWS_ST_BUSY] !== 1'h0 && n < 300) begin
            apb(1'h0, `FWS_OFF_STAT, 32'h0);
            seen_t2 = seen_t2 | rd[`FWS_ST_T2];
            n = n + 1;
         end
         // a poll that runs out of its limit counts as a mismatch
         chk(rd[`FWS_ST_BUSY], 1'h0);
      end
   endtask
   task run(input [1:0] mode);
      begin
         apb(1'h1, `FWS_OFF_CTRL, {29'h0, mode, 1'h1});
         poll;
      end
   endtask
   task t_reset;
      begin
         apb(1'h0, `FWS_OFF_STAT, 32'h0);
         chk(rd, 32'h10);
         apb(1'h0, 12'h018, 32'h0);
         chk(rd, 32'h0);
         chk(err, 32'h1);
         $display("test reset done");
      end
   endtask
   task t_prog;
      begin
         i_flash.data = 8'ha5;
         i_flash.cnt = 3;
         i_flash.busy = 1'h1;
         apb(1'h1, `FWS_OFF_ADDR, 32'h12345);
         apb(1'h1, `FWS_OFF_DATA, 32'ha5);
         apb(1'h1, `FWS_OFF_CTRL, {29'h0, `FWS_MODE_PROG, 1'h1});
         apb(1'h0, `FWS_OFF_STAT, 32'h0);
         chk({rd[`FWS_ST_RDY], rd[`FWS_ST_BUSY]}, 2'h1);
         poll;
         chk(fl_addr, 21'h12345);
         chk(rd[4:0], 5'h12);
         apb(1'h0, `FWS_OFF_RDAT, 32'h0);
         chk(rd[7:0], 8'ha5);
         $display("test program poll done");
      end
   endtask
   task t_toggle;
      begin
         i_flash.erase = 1'h1;
         i_flash.cnt = 4;
         i_flash.busy = 1'h1;
         apb(1'h1, `FWS_OFF_ERSA, 32'h20000);
         run(`FWS_MODE_TOGGLE);
         chk(fl_addr, 21'h20000);
         chk(seen_t2, 1'h1);
         chk(rd[2:0], 3'h2);
         $display("test toggle poll done");
      end
   endtask
   task t_suspend;
      begin
         i_flash.erase = 1'h1;
         i_flash.susp = 1'h1;
         i_flash.cnt = 1000;
         i_flash.busy = 1'h1;
         run(`FWS_MODE_TOGGLE);
         chk(rd[2:0], 3'h2);
         chk(rd[`FWS_ST_T2], 1'h1);
         chk(rd[`FWS_ST_RDY], 1'h1);
         apb(1'h0, `FWS_OFF_RDAT, 32'h0);
         chk(rd[`FWS_POLL_BIT], 1'h1);
         i_flash.susp = 1'h0;
         i_flash.busy = 1'h0;
         $display("test erase suspend done");
      end
   endtask
   task t_cmd_reset;
      begin
         i_flash.got_reset = 1'h0;
         run(`FWS_MODE_RESET);
         chk(rd[3:0], 4'ha);
         chk(i_flash.got_reset, 1'h1);
         $display("test reset command done");
      end
   endtask
   task t_fail;
      begin
         i_flash.erase = 1'h0;
         i_flash.fail = 1'h1;
         i_flash.cnt = 1000;
         i_flash.busy = 1'h1;
         run(`FWS_MODE_TOGGLE);
         chk(rd[3:2], 2'h3);
         chk(i_flash.got_reset, 1'h1);
         chk(rd[`FWS_ST_RDY], 1'h1);
         $display("test fail reset done");
      end
   endtask
   task t_timer(input b);
      begin
         i_flash.erase = 1'h1;
         i_flash.tmr = b;
         i_flash.cnt = 1;
         i_flash.busy = 1'h1;
         run(`FWS_MODE_DQ3);
         chk(rd[`FWS_ST_TIMER], b);
         $display("test timer bit done");
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      #500000;
      fail_count = fail_count + 1;
      test_done;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      t_reset;
      t_prog;
      t_toggle;
      t_suspend;
      t_fail;
      t_cmd_reset;
      t_timer(1'h1);
      t_timer(1'h0);
      test_done;
   end
endmodule // testbench
bind fws_host fws_host_chk #(.AW(AW), .STROBE_CYC(STROBE_CYC)) i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
   .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
